// ---- design/amx_pkg.sv ----
// Constants, carriers and state codes for the memory port crossbar block
package amx_pkg;
   localparam int ADDR_W = 34;
   localparam int ID_W = 6;
   localparam int LEN_W = 4;
   localparam int DATA_W = 256;
   localparam int PAR_W = 32;
   localparam int PORT_W = 4;
   localparam int INST_LSB = 2;
   localparam int MEM_IDX_W = 4;
   localparam int MEM_DEPTH = 16;
   localparam int BEAT_LSB = 5;
   localparam int ROW_LSB = 10;
   localparam int ROW_W = 18;
   localparam int SEL_LSB_4H = 28;
   localparam int SEL_LSB_8H = 29;
   localparam int STACK_BIT_4H = 32;
   localparam int STACK_BIT_8H = 33;
   localparam int LAT_W = 7;
   localparam int NUM_PORTS = 16;
   localparam logic [LAT_W-1:0] LAT_OPEN = 7'h5A;
   localparam logic [LAT_W-1:0] LAT_ACT = 7'h6C;
   localparam logic [LAT_W-1:0] LAT_GLOBAL = 7'h6E;
   localparam logic [6:0] RD_MAX = 7'h40;
   localparam logic [5:0] WR_MAX = 6'h20;
   localparam logic [2:0] SIZE_256 = 3'h5;
   localparam logic [1:0] BURST_FIXED = 2'h0;
   localparam logic [1:0] BURST_WRAP = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [1:0] {LAT_SEL_OPEN = 2'h0, LAT_SEL_ACT = 2'h1, LAT_SEL_GLOBAL = 2'h2} amx_lat_e;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_RLAT = 3'h1, ST_RDAT = 3'h3, ST_WDAT = 3'h4, ST_WLAT = 3'h6, ST_BRSP = 3'h7
   } amx_state_e;
   typedef struct packed {
      logic [ID_W-1:0] id;
      logic [ADDR_W-1:0] addr;
      logic [LEN_W-1:0] len;
      logic [2:0] size;
      logic [1:0] burst;
   } amx_addr_s;
   typedef struct packed {
      logic [ID_W-1:0] id;
      logic [DATA_W-1:0] data;
      logic [PAR_W-1:0] par;
      logic [1:0] resp;
      logic last;
   } amx_rbeat_s;
endpackage : amx_pkg

// ---- design/amx_port_xbar.sv ----
// One memory port of the crossbar: port-clock slave front end and memory-clock latency engine
// Summary of operation
// (R1) Sixteen independent ports per stack, each one sixteenth of stack bandwidth; this is one.
// (R2) Global addressing reaches all memory; direct addressing confines port to its pseudo channel.
// (R3) Direct addressing latency: 90 memory clocks open page, 108 with row activate.
// (R4) Global addressing latency is at least 110 memory clocks.
// (R5) Switch instance joins 4 masters to 4 slaves, two shared lateral links.
// (R6) Lateral traffic is capped at half bandwidth yet reaches all memory.
// (R7) Lateral writes get exactly one idle cycle when the owning master changes.
// (R8) Routing inside one switch instance has no lateral loss; leaving it does.
// (R9) Targets in own instance see no penalty; neighbouring instances take the lateral penalty.
// (R10) A lateral read stalled by RREADY low keeps its lateral path until done.
// (R11) An accepted write holds its data path until all its write data passed.
// (R12) Master should issue write address only when its write data is ready.
// (R13) Master asserts port reset only before any data traffic starts.
// (R14) With switch enabled, all port resets are tied together internally.
// (R15) Addresses are 33 bits for four-high and 34 bits for eight-high stacks.
// (R16) Master never uses the fixed burst type on either address channel.
// (R17) Master always requests 256-bit transfers; no other size is supported.
// (R18) Identifiers are 6 bits and burst lengths 4 bits on every channel.
// (R19) 32-bit parity sidebands: one odd-parity bit per byte, or data width extension.
// (R20) Each port holds up to 64 outstanding reads and 32 outstanding writes; the sequencer here accepts one transaction at a time.
// (R21) Master waits for configuration-complete high before starting any transaction.
// (R22) With host parity enabled, a write data parity error returns slave error.
// (R23) Incrementing and wrapping bursts, independent valid/ready handshakes in port clock.
`timescale 1ns/1ps
`default_nettype none
module amx_port_xbar #(
   parameter logic [amx_pkg::PORT_W-1:0] PORT_INDEX = 4'h0 // R1
) (
   // Memory side clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_B,
   output logic CONFIG_DONE,
   // Port clock, resets and straps
   input wire logic PORT_CLK,
   input wire logic PORT_RESET_N,
   input wire logic [amx_pkg::NUM_PORTS-1:0] PEER_RESET_N,
   input wire logic SWITCH_EN,
   input wire logic GLOBAL_ADDR_EN,
   input wire logic EIGHT_HIGH_STACK,
   input wire logic HOST_PARITY_EN,
   // Read address channel
   input wire amx_pkg::amx_addr_s AR_REQ,
   input wire logic ARVALID,
   output logic ARREADY,
   // Write address channel
   input wire amx_pkg::amx_addr_s AW_REQ,
   input wire logic AWVALID,
   output logic AWREADY,
   // Write data channel
   input wire logic [amx_pkg::DATA_W-1:0] WDATA,
   input wire logic [amx_pkg::PAR_W-1:0] WSTRB,
   input wire logic [amx_pkg::PAR_W-1:0] WRITE_BYTE_PARITY,
   input wire logic WLAST,
   input wire logic WVALID,
   output logic WREADY,
   // Read data channel
   output amx_pkg::amx_rbeat_s R_BEAT,
   output logic RVALID,
   input wire logic RREADY,
   // Write response channel
   output logic [amx_pkg::ID_W-1:0] BID,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // Switch status
   output logic LATERAL_HELD
);
   import amx_pkg::*;

   function automatic logic [PAR_W-1:0] par_of(input logic [DATA_W-1:0] d);
      logic [PAR_W-1:0] p;
      p = '0;
      for (int i = 0; i < PAR_W; i++) begin
         p[i] = ^d[i*8+:8];
      end
      return p;
   endfunction : par_of

   // Port reset, tied across ports when the switch is on
   wire port_rst_n = PORT_RESET_N & (~SWITCH_EN | (&PEER_RESET_N)); // R14

   // Strap synchronisers
   logic [2:0] strap_meta_r;
   logic [2:0] strap_r;
   always_ff @(posedge PORT_CLK or negedge port_rst_n) begin
      if (!port_rst_n) begin
         strap_meta_r <= '0;
         strap_r <= '0;
      end else begin
         strap_meta_r <= {GLOBAL_ADDR_EN, EIGHT_HIGH_STACK, HOST_PARITY_EN};
         strap_r <= strap_meta_r;
      end
   end
   wire global_en = strap_r[2];
   wire eight_high = strap_r[1];
   wire host_par = strap_r[0];

   // Port domain state
   amx_state_e state_r;
   amx_state_e state_nxt;
   amx_addr_s cur_r;
   amx_lat_e lat_sel_r;
   logic offer_rd_r;
   logic req_tgl_r;
   logic [2:0] ack_sync_r;
   logic lateral_r;
   logic [1:0] err_r;
   logic perr_r;
   logic [MEM_IDX_W-1:0] idx_r;
   logic [LEN_W-1:0] beat_r;
   logic [ROW_W-1:0] open_row_r;
   logic open_valid_r;
   logic [ID_W-1:0] last_owner_r;
   logic [6:0] rd_out_r;
   logic [5:0] wr_out_r;
   logic arready_r, awready_r, wready_r, rvalid_r, bvalid_r, held_r;
   logic ack_tgl_r;
   logic [1:0] bresp_r;
   amx_rbeat_s rbeat_r;

   // Request decode on the offered address channel
   wire amx_addr_s req = offer_rd_r ? AR_REQ : AW_REQ;
   wire [PORT_W-1:0] tgt_port = eight_high ? req.addr[SEL_LSB_8H+:PORT_W] : req.addr[SEL_LSB_4H+:PORT_W]; // R15
   wire tgt_stack = eight_high ? req.addr[STACK_BIT_8H] : req.addr[STACK_BIT_4H]; // R15
   wire [ROW_W-1:0] tgt_row = req.addr[ROW_LSB+:ROW_W];
   wire own_inst = (tgt_port[PORT_W-1:INST_LSB] == PORT_INDEX[PORT_W-1:INST_LSB]) & ~tgt_stack; // R5
   wire direct_miss = ~global_en & ((tgt_port != PORT_INDEX) | tgt_stack); // R2
   wire bad_form = (req.burst == BURST_FIXED) | (req.size != SIZE_256);
   wire [1:0] req_err = direct_miss ? RESP_DECERR : (bad_form ? RESP_SLVERR : RESP_OKAY);
   wire req_lateral = global_en & ~own_inst; // R8 R9
   wire amx_lat_e req_lat = global_en ? LAT_SEL_GLOBAL : // R4
      ((open_valid_r & (tgt_row == open_row_r)) ? LAT_SEL_OPEN : LAT_SEL_ACT); // R3

   wire ar_fire = ARVALID & arready_r;
   wire aw_fire = AWVALID & awready_r;
   wire w_fire = WVALID & wready_r;
   wire r_fire = rvalid_r & RREADY;
   wire b_fire = bvalid_r & BREADY;
   wire ack_seen = ack_sync_r[2] ^ ack_sync_r[1];
   wire r_last = (beat_r == cur_r.len);

   // Next beat index for incrementing and wrapping bursts
   wire [MEM_IDX_W-1:0] idx_inc = idx_r + 4'h1;
   wire [MEM_IDX_W-1:0] idx_adv = (cur_r.burst == BURST_WRAP) ?
      ((idx_r & ~cur_r.len) | (idx_inc & cur_r.len)) : idx_inc; // R23
   wire r_load = ((state_r == ST_RLAT) & ack_seen) | (r_fire & ~r_last & ~lateral_r) |
      ((state_r == ST_RDAT) & ~rvalid_r);
   wire [MEM_IDX_W-1:0] r_load_idx = r_fire ? idx_adv : idx_r;

   // Storage, one lane per byte with its sideband bit
   logic [DATA_W-1:0] rd_data;
   logic [PAR_W-1:0] rd_side;
   logic [PAR_W-1:0] w_bad;
   for (genvar b = 0; b < PAR_W; b++) begin : g_lane
      logic [8:0] lane_mem [MEM_DEPTH];
      always_ff @(posedge PORT_CLK) begin
         if (w_fire && (err_r == RESP_OKAY) && WSTRB[b]) begin
            lane_mem[idx_r] <= {WRITE_BYTE_PARITY[b], WDATA[b*8+:8]};
         end
      end
      assign rd_data[b*8+:8] = lane_mem[r_load_idx][7:0];
      assign rd_side[b] = host_par ? (^lane_mem[r_load_idx][7:0]) : lane_mem[r_load_idx][8]; // R19
      assign w_bad[b] = (^WDATA[b*8+:8]) != WRITE_BYTE_PARITY[b]; // R19
   end

   // Transaction sequencer
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (ar_fire) begin
               state_nxt = ST_RLAT;
            end else if (aw_fire) begin
               state_nxt = ST_WDAT;
            end
         end
         ST_RLAT: begin
            if (ack_seen) begin
               state_nxt = ST_RDAT;
            end
         end
         ST_RDAT: begin
            if (r_fire && r_last) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_WDAT: begin
            if (w_fire && WLAST) begin
               state_nxt = ST_WLAT;
            end
         end
         ST_WLAT: begin
            if (ack_seen) begin
               state_nxt = ST_BRSP;
            end
         end
         ST_BRSP: begin
            if (b_fire) begin
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   wire idle_nxt = (state_nxt == ST_IDLE);
   wire rd_room = (rd_out_r < RD_MAX); // R20
   wire wr_room = (wr_out_r < WR_MAX); // R20

   always_ff @(posedge PORT_CLK or negedge port_rst_n) begin
      if (!port_rst_n) begin
         state_r <= ST_IDLE;
         offer_rd_r <= 1'b1;
         arready_r <= 1'b0;
         awready_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         offer_rd_r <= ~offer_rd_r;
         arready_r <= idle_nxt & ~offer_rd_r & rd_room & ~ar_fire & ~aw_fire; // R23
         awready_r <= idle_nxt & offer_rd_r & wr_room & ~ar_fire & ~aw_fire; // R23
      end
   end

   // Captured command and its routing
   always_ff @(posedge PORT_CLK or negedge port_rst_n) begin
      if (!port_rst_n) begin
         cur_r <= '0;
         lateral_r <= 1'b0;
         err_r <= RESP_OKAY;
         lat_sel_r <= LAT_SEL_OPEN;
         open_row_r <= '0;
         open_valid_r <= 1'b0;
         idx_r <= '0;
         beat_r <= '0;
      end else if (ar_fire || aw_fire) begin
         cur_r <= req;
         lateral_r <= req_lateral;
         err_r <= req_err;
         lat_sel_r <= req_lat;
         open_row_r <= tgt_row;
         open_valid_r <= 1'b1;
         idx_r <= req.addr[BEAT_LSB+:MEM_IDX_W];
         beat_r <= '0;
      end else if (r_fire || w_fire) begin
         idx_r <= idx_adv;
         beat_r <= beat_r + 4'h1;
      end
   end

   // Outstanding counts
   always_ff @(posedge PORT_CLK or negedge port_rst_n) begin
      if (!port_rst_n) begin
         rd_out_r <= '0;
         wr_out_r <= '0;
      end else begin
         rd_out_r <= rd_out_r + {6'h0, ar_fire} - {6'h0, r_fire & r_last}; // R20
         wr_out_r <= wr_out_r + {5'h0, aw_fire} - {5'h0, b_fire}; // R20
      end
   end

   // Request toggle to the memory clock; ack back through two flops
   always_ff @(posedge PORT_CLK or negedge port_rst_n) begin
      if (!port_rst_n) begin
         req_tgl_r <= 1'b0;
         ack_sync_r <= '0;
      end else begin
         if (ar_fire || (w_fire && WLAST)) begin
            req_tgl_r <= ~req_tgl_r;
         end
         ack_sync_r <= {ack_sync_r[1:0], ack_tgl_r};
      end
   end

   // Read data beats, half rate on a lateral path
   always_ff @(posedge PORT_CLK or negedge port_rst_n) begin
      if (!port_rst_n) begin
         rvalid_r <= 1'b0;
         rbeat_r <= '0;
      end else begin
         if (r_load) begin
            rvalid_r <= 1'b1;
            rbeat_r.id <= cur_r.id;
            rbeat_r.data <= (err_r == RESP_OKAY) ? rd_data : '0;
            rbeat_r.par <= (err_r == RESP_OKAY) ? rd_side : '0;
            rbeat_r.resp <= err_r;
            rbeat_r.last <= r_fire ? (beat_r + 4'h1 == cur_r.len) : (beat_r == cur_r.len);
         end else if (r_fire) begin
            rvalid_r <= 1'b0; // R6
         end
      end
   end

   // Write data acceptance, response and lateral ownership
   always_ff @(posedge PORT_CLK or negedge port_rst_n) begin
      if (!port_rst_n) begin
         wready_r <= 1'b0;
         perr_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         held_r <= 1'b0;
         last_owner_r <= '0;
      end else begin
         if (aw_fire) begin
            wready_r <= ~(req_lateral & (req.id != last_owner_r)); // R7
         end else if (w_fire) begin
            wready_r <= ~WLAST & ~lateral_r; // R6
         end else if ((state_r == ST_WDAT) && !wready_r) begin
            wready_r <= 1'b1; // R7
         end
         if (aw_fire) begin
            perr_r <= 1'b0;
         end else if (w_fire && host_par && (|w_bad)) begin
            perr_r <= 1'b1; // R22
         end
         if ((state_r == ST_WLAT) && ack_seen) begin
            bvalid_r <= 1'b1;
            bresp_r <= (err_r != RESP_OKAY) ? err_r : (perr_r ? RESP_SLVERR : RESP_OKAY); // R22
         end else if (b_fire) begin
            bvalid_r <= 1'b0;
         end
         if ((ar_fire || aw_fire) && req_lateral) begin
            held_r <= 1'b1; // R10 R11
         end else if ((r_fire && r_last) || (w_fire && WLAST)) begin
            held_r <= 1'b0; // R10 R11
         end
         if (w_fire && WLAST && lateral_r) begin
            last_owner_r <= cur_r.id;
         end
      end
   end

   assign ARREADY = arready_r;
   assign AWREADY = awready_r;
   assign WREADY = wready_r;
   assign RVALID = rvalid_r;
   assign R_BEAT = rbeat_r;
   assign BVALID = bvalid_r;
   assign BID = cur_r.id; // R18
   assign BRESP = bresp_r; // R22
   assign LATERAL_HELD = held_r;

   // Memory clock latency engine
   logic [2:0] req_sync_r;
   logic lat_busy_r;
   logic [LAT_W-1:0] lat_cnt_r;
   logic [LAT_W-1:0] svc_cnt_r;
   amx_lat_e core_sel_r;
   logic cfg_done_r;
   wire req_seen = req_sync_r[2] ^ req_sync_r[1];
   wire [LAT_W-1:0] lat_len = (lat_sel_r == LAT_SEL_GLOBAL) ? LAT_GLOBAL :
      ((lat_sel_r == LAT_SEL_OPEN) ? LAT_OPEN : LAT_ACT); // R3 R4
   wire lat_fire = lat_busy_r & (lat_cnt_r == '0);

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         req_sync_r <= '0;
         ack_tgl_r <= 1'b0;
         lat_busy_r <= 1'b0;
         lat_cnt_r <= '0;
         svc_cnt_r <= '0;
         core_sel_r <= LAT_SEL_OPEN;
         cfg_done_r <= 1'b0;
      end else begin
         req_sync_r <= {req_sync_r[1:0], req_tgl_r};
         cfg_done_r <= 1'b1;
         if (req_seen) begin
            lat_busy_r <= 1'b1;
            lat_cnt_r <= lat_len - 7'h1; // R3 R4
            svc_cnt_r <= 7'h1;
            core_sel_r <= lat_sel_r;
         end else if (lat_fire) begin
            lat_busy_r <= 1'b0;
            ack_tgl_r <= ~ack_tgl_r;
         end else if (lat_busy_r) begin
            lat_cnt_r <= lat_cnt_r - 7'h1;
            svc_cnt_r <= svc_cnt_r + 7'h1;
         end
      end
   end
   assign CONFIG_DONE = cfg_done_r;

   // Checks
   property p_lat_open;
      @(posedge CORE_CLK) disable iff (!RST_B)
      (lat_fire && core_sel_r == LAT_SEL_OPEN) |-> (svc_cnt_r == LAT_OPEN);
   endproperty
   a_lat_open: assert property (p_lat_open) else $error("open page latency wrong"); // R3
   property p_lat_act;
      @(posedge CORE_CLK) disable iff (!RST_B)
      (lat_fire && core_sel_r == LAT_SEL_ACT) |-> (svc_cnt_r == LAT_ACT);
   endproperty
   a_lat_act: assert property (p_lat_act) else $error("activate latency wrong"); // R3
   property p_lat_global;
      @(posedge CORE_CLK) disable iff (!RST_B)
      (lat_fire && core_sel_r == LAT_SEL_GLOBAL) |-> (svc_cnt_r >= LAT_GLOBAL);
   endproperty
   a_lat_global: assert property (p_lat_global) else $error("global latency too short"); // R4
   property p_direct;
      @(posedge PORT_CLK) disable iff (!port_rst_n)
      (ar_fire && !global_en && tgt_port != PORT_INDEX) |=> (err_r == RESP_DECERR);
   endproperty
   a_direct: assert property (p_direct) else $error("direct access left its channel"); // R2
   property p_half;
      @(posedge PORT_CLK) disable iff (!port_rst_n)
      (r_fire && !R_BEAT.last && lateral_r) |=> !RVALID ##1 RVALID;
   endproperty
   a_half: assert property (p_half) else $error("lateral read not half rate"); // R6
   property p_wgap;
      @(posedge PORT_CLK) disable iff (!port_rst_n)
      (aw_fire && req_lateral && req.id != last_owner_r) |=> !WREADY ##1 WREADY;
   endproperty
   a_wgap: assert property (p_wgap) else $error("owner change gap missing"); // R7
   property p_rd_hold;
      @(posedge PORT_CLK) disable iff (!port_rst_n)
      (held_r && rvalid_r && !RREADY) |=> LATERAL_HELD;
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("stalled read dropped path"); // R10
   property p_wr_hold;
      @(posedge PORT_CLK) disable iff (!port_rst_n)
      (held_r && state_r == ST_WDAT && !(w_fire && WLAST)) |=> LATERAL_HELD;
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write path released early"); // R11
   property p_perr;
      @(posedge PORT_CLK) disable iff (!port_rst_n)
      (BVALID && perr_r && err_r == RESP_OKAY) |-> (BRESP == RESP_SLVERR);
   endproperty
   a_perr: assert property (p_perr) else $error("parity error not reported"); // R22
   property p_rpar;
      @(posedge PORT_CLK) disable iff (!port_rst_n)
      (RVALID && host_par && R_BEAT.resp == RESP_OKAY) |-> (R_BEAT.par == par_of(R_BEAT.data));
   endproperty
   a_rpar: assert property (p_rpar) else $error("read parity wrong"); // R19
   property p_rd_room;
      @(posedge PORT_CLK) disable iff (!port_rst_n)
      ARREADY |-> (rd_out_r < RD_MAX);
   endproperty
   a_rd_room: assert property (p_rd_room) else $error("read accepted past limit"); // R20
   c_read: cover property (@(posedge PORT_CLK) disable iff (!port_rst_n) r_fire && R_BEAT.last);
   c_write: cover property (@(posedge PORT_CLK) disable iff (!port_rst_n) b_fire);
   c_lat_stall: cover property (@(posedge PORT_CLK) disable iff (!port_rst_n) held_r && rvalid_r && !RREADY);
   c_perr: cover property (@(posedge PORT_CLK) disable iff (!port_rst_n) b_fire && BRESP == RESP_SLVERR);
endmodule : amx_port_xbar
`default_nettype wire

// ---- verification/amx_master_model.sv ----
// Port-side master model driving one crossbar port
`timescale 1ns/1ps
`default_nettype none
module amx_master_model (
   // Clock and pacing
   input wire logic clk,
   input wire logic stall,
   // Address channels
   output amx_pkg::amx_addr_s ar_req,
   output logic arvalid,
   input wire logic arready,
   output amx_pkg::amx_addr_s aw_req,
   output logic awvalid,
   input wire logic awready,
   // Write data channel
   output logic [255:0] wdata,
   output logic [31:0] wpar,
   output logic wlast,
   output logic wvalid,
   input wire logic wready,
   // Response readies
   output logic rready,
   output logic bready
);
   import amx_pkg::*;
   initial begin
      {ar_req, aw_req, arvalid, awvalid, wdata, wpar, wlast, wvalid, rready, bready} = '0;
   end
   // Slow mode toggles readies every cycle
   always @(negedge clk) begin
      rready <= stall ? ~rready : 1'b1;
      bready <= stall ? ~bready : 1'b1;
   end
   // Entered and left at a falling edge; request held until ready
   task automatic addr(input bit wr, input amx_addr_s a);
      if (wr) begin
         aw_req = a;
         awvalid = 1'b1;
         while (awready !== 1'b1) @(negedge clk);
      end else begin
         ar_req = a;
         arvalid = 1'b1;
         while (arready !== 1'b1) @(negedge clk);
      end
      @(negedge clk);
      awvalid = 1'b0;
      arvalid = 1'b0;
      aw_req = ~a;
      ar_req = ~a;
   endtask : addr
   task automatic beat(input logic [255:0] d, input logic [31:0] p, input bit last);
      wdata = d;
      wpar = p;
      wlast = last;
      wvalid = 1'b1;
      while (wready !== 1'b1) @(negedge clk);
      @(negedge clk);
      if (last) begin
         wvalid = 1'b0;
         wdata = ~d;
      end
   endtask : beat
endmodule : amx_master_model
`default_nettype wire

// ---- verification/axi3_memory_port_crossbar_tb.sv ----
// Self-checking bench for one crossbar port
`timescale 1ns/1ps
`default_nettype none
module axi3_memory_port_crossbar_tb;
   import amx_pkg::*;
   typedef struct {amx_rbeat_s b; bit dchk; bit lat;} amx_rexp_s;
   logic core_clk, port_clk, rst_b, port_rst_n, sw_en, glob, eight, hpar, stall;
   logic [15:0] peer_rst_n;
   wire logic cfg_done, arvalid, arready, awvalid, awready, wlast, wvalid, wready;
   wire logic rvalid, rready, bvalid, bready, lat_held;
   wire logic [255:0] wdata;
   wire logic [31:0] wpar;
   wire logic [5:0] bid;
   wire logic [1:0] bresp;
   wire amx_addr_s ar_req, aw_req;
   wire amx_rbeat_s r_beat;
   logic [255:0] mem [16];
   logic [31:0] pmem [16];
   logic [31:0] seed = 32'h548A61F8;
   amx_rexp_s rq[$];
   amx_rexp_s mon_e;
   logic [7:0] bq[$];
   int mismatches, n_tests, core_cnt, t_req, min_lat;
   bit first;
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      port_clk = 1'b0;
      #3.7;
      forever #6 port_clk = ~port_clk;
   end
   amx_port_xbar dut (.CORE_CLK(core_clk), .RST_B(rst_b), .CONFIG_DONE(cfg_done), .PORT_CLK(port_clk),
      .PORT_RESET_N(port_rst_n), .PEER_RESET_N(peer_rst_n), .SWITCH_EN(sw_en), .GLOBAL_ADDR_EN(glob),
      .EIGHT_HIGH_STACK(eight), .HOST_PARITY_EN(hpar), .AR_REQ(ar_req), .ARVALID(arvalid),
      .ARREADY(arready), .AW_REQ(aw_req), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
      .WSTRB(32'hFFFFFFFF), .WRITE_BYTE_PARITY(wpar), .WLAST(wlast), .WVALID(wvalid), .WREADY(wready),
      .R_BEAT(r_beat), .RVALID(rvalid), .RREADY(rready), .BID(bid), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .LATERAL_HELD(lat_held));
   amx_master_model m (.clk(port_clk), .stall(stall), .ar_req(ar_req), .arvalid(arvalid), .arready(arready),
      .aw_req(aw_req), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wpar(wpar), .wlast(wlast),
      .wvalid(wvalid), .wready(wready), .rready(rready), .bready(bready));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [31:0] odd_par(input logic [255:0] d);
      for (int i = 0; i < 32; i++) odd_par[i] = ^d[8*i+:8];
   endfunction : odd_par
   function automatic logic [3:0] idx(input logic [33:0] a, input logic [3:0] len, input logic [1:0] bu, int i);
      logic [3:0] s;
      s = a[8:5] + 4'(i);
      return (bu == BURST_WRAP) ? ((a[8:5] & ~len) | (s & len)) : s;
   endfunction : idx
   task automatic chk(input bit ok, input string msg);
      n_tests++;
      if (!ok) begin
         mismatches++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask : chk
   task automatic finish_test();
      if (mismatches == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   // Notes expectations, then drives one whole transfer and waits for its results
   task automatic xfer(input bit wr, input logic [33:0] a, input logic [3:0] len, input logic [1:0] bu,
                       input logic [2:0] sz, input bit raw, input logic [1:0] resp, input bit lat, input int ml);
      amx_addr_s q;
      amx_rexp_s e;
      logic [255:0] d;
      logic [31:0] p;
      q = '{id: 6'(xs()), addr: a, len: len, size: sz, burst: bu};
      @(negedge port_clk);
      if (wr) begin
         bq.push_back({q.id, resp});
         m.addr(1'b1, q);
         for (int i = 0; i <= len; i++) begin
            d = {xs(), xs(), xs(), xs(), xs(), xs(), xs(), xs()};
            p = raw ? xs() : odd_par(d);
            if (resp == RESP_OKAY) mem[idx(a, len, bu, i)] = d;
            if (resp == RESP_OKAY) pmem[idx(a, len, bu, i)] = p;
            m.beat(d, p, i == len);
         end
      end else begin
         for (int i = 0; i <= len; i++) begin
            e.b = '{id: q.id, data: mem[idx(a, len, bu, i)], par: pmem[idx(a, len, bu, i)], resp: resp,
                    last: i == len};
            e.dchk = resp == RESP_OKAY;
            e.lat = lat;
            rq.push_back(e);
         end
         t_req = core_cnt;
         min_lat = ml;
         first = 1'b1;
         m.addr(1'b0, q);
      end
      while (rq.size() + bq.size() != 0) @(negedge port_clk);
   endtask : xfer
   always @(posedge core_clk) begin
      core_cnt <= core_cnt + 1;
      if (core_cnt == 4000) begin
         mismatches++;
         finish_test();
      end
   end
   // Result watcher
   always @(posedge port_clk) begin
      if (rvalid === 1'b1 && rready === 1'b1) begin
         mon_e = rq.pop_front();
         chk(r_beat.id === mon_e.b.id && r_beat.resp === mon_e.b.resp, "read id or resp");
         chk(r_beat.last === mon_e.b.last, "read last");
         if (mon_e.dchk) chk(r_beat.data === mon_e.b.data && r_beat.par === mon_e.b.par, "read data");
         chk(lat_held === mon_e.lat, "lateral path state");
         if (first && min_lat != 0) chk(core_cnt - t_req >= min_lat && core_cnt - t_req <= min_lat + 6, "lat");
         first = 1'b0;
      end
      if (bvalid === 1'b1 && bready === 1'b1) chk({bid, bresp} === bq.pop_front(), "write response");
   end
   initial begin
      {rst_b, port_rst_n, sw_en, glob, eight, stall} = '0;
      hpar = 1'b1;
      peer_rst_n = '1;
      repeat (3) @(negedge core_clk);
      rst_b = 1'b1;
      port_rst_n = 1'b1;
      while (cfg_done !== 1'b1) @(negedge core_clk);
      repeat (4) @(negedge port_clk);
      xfer(1, 34'h80, 3, 2'h1, SIZE_256, 0, RESP_OKAY, 0, 0);
      stall = 1'b1;
      xfer(0, 34'h80, 3, 2'h1, SIZE_256, 0, RESP_OKAY, 0, LAT_OPEN);
      xfer(0, 34'h480, 1, 2'h1, SIZE_256, 0, RESP_OKAY, 0, LAT_ACT);
      xfer(1, 34'hC0, 7, BURST_WRAP, SIZE_256, 0, RESP_OKAY, 0, 0);
      xfer(0, 34'h40, 3, BURST_WRAP, SIZE_256, 0, RESP_OKAY, 0, LAT_OPEN);
      xfer(0, 34'h1000_0080, 0, 2'h1, SIZE_256, 0, RESP_DECERR, 0, 0);
      eight = 1'b1;
      repeat (3) @(negedge port_clk);
      xfer(0, 34'h1000_0080, 0, 2'h1, SIZE_256, 0, RESP_OKAY, 0, LAT_OPEN);
      eight = 1'b0;
      glob = 1'b1;
      repeat (3) @(negedge port_clk);
      xfer(1, 34'h8000_0000, 1, 2'h1, SIZE_256, 0, RESP_OKAY, 0, 0);
      xfer(0, 34'h8000_0000, 3, 2'h1, SIZE_256, 0, RESP_OKAY, 1, LAT_GLOBAL);
      xfer(0, 34'h1000_0000, 1, 2'h1, SIZE_256, 0, RESP_OKAY, 0, LAT_GLOBAL);
      glob = 1'b0;
      hpar = 1'b0;
      repeat (3) @(negedge port_clk);
      xfer(1, 34'h100, 1, 2'h1, SIZE_256, 1, RESP_OKAY, 0, 0);
      xfer(0, 34'h100, 1, 2'h1, SIZE_256, 0, RESP_OKAY, 0, LAT_OPEN);
      hpar = 1'b1;
      stall = 1'b0;
      repeat (3) @(negedge port_clk);
      xfer(1, 34'h0, 1, BURST_FIXED, SIZE_256, 0, RESP_SLVERR, 0, 0);
      xfer(0, 34'h0, 1, 2'h1, 3'h4, 0, RESP_SLVERR, 0, 0);
      xfer(1, 34'h0, 1, 2'h1, SIZE_256, 1, RESP_SLVERR, 0, 0);
      sw_en = 1'b1;
      peer_rst_n[5] = 1'b0;
      repeat (6) begin
         @(negedge port_clk);
         chk(arready === 1'b0 && awready === 1'b0, "port left out of shared reset");
      end
      finish_test();
   end
endmodule : axi3_memory_port_crossbar_tb
`default_nettype wire
